/* File: shared/perf_event_pkg.sv */
// perf_event_pkg: event selections, counter widths and reset values of the
// performance-event counting unit.
// assumes: every user sits on the single core clock.
package perf_event_pkg;

	localparam int CNT_W  = 40;
	localparam int CODE_W = 8;

	localparam logic [CODE_W-1:0] EV_L2_REFUSAL   = 8'h30;
	localparam logic [CODE_W-1:0] EV_L2_IDLE      = 8'h32;
	localparam logic [CODE_W-1:0] EV_UNHALTED     = 8'h3C;
	localparam logic [CODE_W-1:0] EV_L1_PREFETCH  = 8'h4F;
	localparam logic [CODE_W-1:0] EV_SNOOP_RESP   = 8'h77;
	localparam logic [CODE_W-1:0] EV_SHARE_SNOOP  = 8'h78;
	localparam logic [CODE_W-1:0] EV_BUS_IDLE     = 8'h7D;

	localparam logic [CODE_W-1:0] UM_NONE         = 8'h00;
	localparam logic [CODE_W-1:0] UM_CORE_CYCLES  = 8'h00;
	localparam logic [CODE_W-1:0] UM_REF_CYCLES   = 8'h01;
	localparam logic [CODE_W-1:0] UM_SERIAL       = 8'h02;
	localparam logic [CODE_W-1:0] UM_SHARE        = 8'h01;

	localparam logic [CODE_W-1:0] CODE_RESET      = 8'h00;
	localparam logic [CNT_W-1:0]  CNT_RESET       = 40'h00_0000_0000;
	localparam logic [CNT_W-1:0]  CNT_ONE         = 40'h00_0000_0001;

	typedef enum logic [1:0] {
		RESP_CLEAN = 2'b00,
		RESP_HIT   = 2'b01,
		RESP_HIT_MODIFIED_RESPONSE  = 2'b10,
		RESP_NONE  = 2'b11
	} snoop_resp_type;

	// one bit per countable condition, qualified in the counting unit
	typedef struct packed {
		logic l2Refusal;
		logic l2Idle;
		logic coreCycle;
		logic refCycle;
		logic serialCycle;
		logic prefetchIssue;
		logic shareSnoop;
		logic busIdle;
		logic snoopResp;
	} cond_type;

	typedef struct packed {
		logic [CODE_W-1:0] evCode;
		logic [CODE_W-1:0] uMask;
		logic [CNT_W-1:0]  count;
		logic [CNT_W-1:0]  dispCount;
		logic [CNT_W-1:0]  stallCount;
		logic              pfPending;
		logic              snoopGrant;
		logic              storeGrant;
		logic              coreActive;
	} state_type;

	localparam state_type STATE_RESET = '{
		evCode:     CODE_RESET,
		uMask:      CODE_RESET,
		count:      CNT_RESET,
		dispCount:  CNT_RESET,
		stallCount: CNT_RESET,
		pfPending:  1'b0,
		snoopGrant: 1'b0,
		storeGrant: 1'b0,
		coreActive: 1'b0
	};

endpackage

/* File: shared/event_sel_if.sv */
// event_sel_if: selection and condition bits handed to the event decoder,
// and the increment it returns.
// assumes: decoder is purely combinational on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface event_sel_if;
	import perf_event_pkg::*;

	logic [CODE_W-1:0] evCode;
	logic [CODE_W-1:0] uMask;
	cond_type          cond;
	logic              hit;

	modport counter (output evCode, output uMask, output cond, input hit);
	modport decoder (input evCode, input uMask, input cond, output hit);
endinterface
`default_nettype wire

/* File: design/event_decode.sv */
// event_decode: maps event code and unit mask onto one condition bit.
// assumes: conditions are already qualified for halt and bus tick.
`timescale 1ns/1ps
`default_nettype none
module event_decode
	import perf_event_pkg::*;
(
	// selection and conditions
	event_sel_if.decoder sel
);

	always_comb begin
		sel.hit = 1'b0;
		case (sel.evCode)
			EV_L2_REFUSAL:  sel.hit = sel.cond.l2Refusal;
			EV_L2_IDLE:     sel.hit = sel.cond.l2Idle;
			EV_UNHALTED: begin
				case (sel.uMask)
					UM_CORE_CYCLES: sel.hit = sel.cond.coreCycle;
					UM_REF_CYCLES:  sel.hit = sel.cond.refCycle;
					UM_SERIAL:      sel.hit = sel.cond.serialCycle;
					default:        sel.hit = 1'b0;
				endcase
			end
			EV_L1_PREFETCH: sel.hit = (sel.uMask == UM_NONE) & sel.cond.prefetchIssue;
			EV_SHARE_SNOOP: sel.hit = (sel.uMask == UM_SHARE) & sel.cond.shareSnoop;
			EV_BUS_IDLE:    sel.hit = (sel.uMask == UM_NONE) & sel.cond.busIdle;
			EV_SNOOP_RESP:  sel.hit = (sel.uMask == UM_NONE) & sel.cond.snoopResp;
			default:        sel.hit = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

/* File: design/perf_event_counting.sv */
// perf_event_counting: one programmable event counter of a core, plus the
// prefetch retry holder and the store-port arbiter whose activity it counts.
// assumes: all strobes come from logic on clk; busTick marks one core cycle
// per bus clock cycle.
//
// How it works
// - Code 30H counts every cycle in which the second-level cache refuses a new request.
// - Code 32H counts every cycle with neither a first-level request nor a prefetch issued to the L2.
// - Code 3C with mask 00H counts core cycles while the core is not halted.
// - Code 3C with mask 01H counts bus cycles while the core is not halted.
// - Code 3C with mask 02H counts bus cycles with this core running and the other core halted.
// - Code 4FH with mask 00H counts every prefetch request the data cache issues to the L2.
// - A refused prefetch stays pending and is issued again until the L2 takes it.
// - Code 78H with mask 01H counts snoops into the data cache for lines the other core needs.
// - Such a snoop counts only if the line is absent there, or read-only there and wanted for writing.
// - Other-core snoops use the data cache store port and so compete with stores for it.
// - Code 7DH with mask 00H counts bus cycles with no transaction of this core outstanding.
// - Code 77H with mask 00H counts clean, hit and hit-modified answers to external snoops.
// - Each unhalted core cycle lands in exactly one of dispatching or not-dispatching counts.
// - The unhalted core, reference and bus cycle counts stop while halted, even under snoop.
// - The core is active when running non-halt code or while being snooped.
`timescale 1ns/1ps
`default_nettype none
module perf_event_counting
	import perf_event_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// event selection
	input  wire logic              selectLoad,
	input  wire logic [CODE_W-1:0] selectCode,
	input  wire logic [CODE_W-1:0] selectMask,
	input  wire logic              counterClear,
	// core state
	input  wire logic              coreHalted,
	input  wire logic              otherCoreHalted,
	input  wire logic              beingSnooped,
	input  wire logic              rsDispatch,
	input  wire logic              busTick,
	// second-level cache traffic
	input  wire logic              l2Refuse,
	input  wire logic              l1RequestToL2,
	input  wire logic              prefetchNew,
	// store port
	input  wire logic              storeRequest,
	input  wire logic              snoopRequest,
	input  wire logic              snoopLineAbsent,
	input  wire logic              snoopLineReadOnly,
	input  wire logic              snoopOtherWrites,
	// bus unit
	input  wire logic              busOutstanding,
	input  wire logic              snoopRespValid,
	input  wire snoop_resp_type    snoopRespKind,
	// results
	output var  logic [CNT_W-1:0]  eventCount,
	output var  logic [CNT_W-1:0]  dispatchCycles,
	output var  logic [CNT_W-1:0]  stallCycles,
	output var  logic [CODE_W-1:0] activeCode,
	output var  logic [CODE_W-1:0] activeMask,
	output var  logic              coreActive,
	// prefetch and store port
	output var  logic              l2PrefetchRequest,
	output var  logic              snoopGrant,
	output var  logic              storeGrant
);

	state_type state_reg;
	state_type state_next;

	event_sel_if sel ();

	logic shareCause;
	logic prefetchTaken;
	logic respCounted;

	// counters wrap; a wrap at this width comes after 2^40 counts, minutes at GHz core rates
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] value, input logic step);
		bump = step ? value + CNT_ONE : value;
	endfunction

	event_decode decoder (
		.sel (sel)
	);

	always_comb begin
		shareCause    = snoopLineAbsent | (snoopLineReadOnly & snoopOtherWrites);
		prefetchTaken = state_reg.pfPending & ~l2Refuse;
		respCounted   = snoopRespValid & (snoopRespKind != RESP_NONE);

		sel.evCode             = state_reg.evCode;
		sel.uMask              = state_reg.uMask;
		sel.cond.l2Refusal     = l2Refuse;
		sel.cond.l2Idle        = ~l1RequestToL2 & ~state_reg.pfPending;
		// halt gates these three; snooping a halted core does not revive them
		sel.cond.coreCycle     = ~coreHalted;
		sel.cond.refCycle      = ~coreHalted & busTick;
		sel.cond.serialCycle   = ~coreHalted & otherCoreHalted & busTick;
		sel.cond.prefetchIssue = state_reg.pfPending;
		sel.cond.shareSnoop    = snoopRequest & shareCause;
		sel.cond.busIdle       = busTick & ~busOutstanding;
		sel.cond.snoopResp     = respCounted;
	end

	always_comb begin
		state_next = state_reg;

		if (selectLoad) begin
			state_next.evCode = selectCode;
			state_next.uMask  = selectMask;
		end

		if (counterClear | selectLoad) begin
			state_next.count = CNT_RESET;
		end else begin
			state_next.count = bump(state_reg.count, sel.hit);
		end

		// exactly one of the two advances in an unhalted cycle
		if (counterClear) begin
			state_next.dispCount  = CNT_RESET;
			state_next.stallCount = CNT_RESET;
		end else begin
			state_next.dispCount  = bump(state_reg.dispCount, ~coreHalted & rsDispatch);
			state_next.stallCount = bump(state_reg.stallCount, ~coreHalted & ~rsDispatch);
		end

		// a new request while one waits merges into it; the set wins over the take
		state_next.pfPending  = prefetchNew | (state_reg.pfPending & ~prefetchTaken);

		// snoops take priority so the other core is never starved; stores wait
		state_next.snoopGrant = snoopRequest;
		state_next.storeGrant = storeRequest & ~snoopRequest;

		state_next.coreActive = ~coreHalted | beingSnooped;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign eventCount        = state_reg.count;
	assign dispatchCycles    = state_reg.dispCount;
	assign stallCycles       = state_reg.stallCount;
	assign activeCode        = state_reg.evCode;
	assign activeMask        = state_reg.uMask;
	assign coreActive        = state_reg.coreActive;
	assign l2PrefetchRequest = state_reg.pfPending;
	assign snoopGrant        = state_reg.snoopGrant;
	assign storeGrant        = state_reg.storeGrant;

endmodule
`default_nettype wire

/* File: verification/perf_event_asserts.sv */
// perf_event_asserts: cycle relations at the ports of the event counter.
// assumes: one clock, synchronous reset, bound to perf_event_counting.
`timescale 1ns/1ps
`default_nettype none
module perf_event_asserts
	import perf_event_pkg::*;
(
	// watched ports
	input wire logic              clk, rst, selectLoad, counterClear, coreHalted, beingSnooped,
	input wire logic              busTick, l2Refuse, snoopRequest, l2PrefetchRequest,
	input wire logic              coreActive, snoopGrant, storeGrant,
	input wire logic [CODE_W-1:0] selectCode, activeCode, activeMask,
	input wire logic [CNT_W-1:0]  eventCount, dispatchCycles, stallCycles
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic keep;
	logic unh;
	// load and clear both win over a hit
	assign keep = !selectLoad && !counterClear;
	assign unh  = activeCode == EV_UNHALTED && keep;
	property p_refusal;
		activeCode == EV_L2_REFUSAL && l2Refuse && keep |=> eventCount == $past(eventCount) + CNT_ONE;
	endproperty
	a_refusal: assert property (p_refusal) else $error("refused cycle not counted");
	property p_core;
		unh && activeMask == UM_CORE_CYCLES && !coreHalted |=> eventCount == $past(eventCount) + CNT_ONE;
	endproperty
	a_core: assert property (p_core) else $error("core cycle not counted");
	property p_ref;
		unh && activeMask == UM_REF_CYCLES && !coreHalted && busTick |=> eventCount == $past(eventCount) + CNT_ONE;
	endproperty
	a_ref: assert property (p_ref) else $error("bus cycle not counted");
	property p_halt;
		unh && coreHalted |=> $stable(eventCount);
	endproperty
	a_halt: assert property (p_halt) else $error("cycle count moved while halted");
	property p_retry;
		l2PrefetchRequest && l2Refuse |=> l2PrefetchRequest;
	endproperty
	a_retry: assert property (p_retry) else $error("refused prefetch dropped");
	property p_port;
		snoopRequest |=> snoopGrant && !storeGrant;
	endproperty
	a_port: assert property (p_port) else $error("snoop lost store port");
	property p_split;
		!coreHalted && !counterClear |=> dispatchCycles + stallCycles == $past(dispatchCycles + stallCycles) + CNT_ONE;
	endproperty
	a_split: assert property (p_split) else $error("cycle not split exactly once");
	property p_load;
		selectLoad |=> activeCode == $past(selectCode) && eventCount == CNT_RESET;
	endproperty
	a_load: assert property (p_load) else $error("selection not loaded");
	property p_active;
		1'b1 |=> coreActive == ($past(beingSnooped) || !$past(coreHalted));
	endproperty
	a_active: assert property (p_active) else $error("core activity wrong");
	c_retry: cover property (l2PrefetchRequest && l2Refuse);
	c_snoop: cover property (unh && coreHalted && beingSnooped);
	c_port: cover property (snoopRequest ##1 storeGrant);
endmodule
bind perf_event_counting perf_event_asserts chk_u (.*);
`default_nettype wire

/* File: verification/bus_tick_source.sv */
// bus_tick_source: the bus unit's view of its clock, one tick per RATIO cycles.
// assumes: bus clock is an exact divide of clk.
`timescale 1ns/1ps
`default_nettype none
module bus_tick_source #(
	parameter int RATIO = 4
) (
	input  wire logic clk,
	input  wire logic rst,
	output var  logic busTick
);
	int phase_reg;
	always_ff @(posedge clk) begin
		phase_reg <= (rst || phase_reg == RATIO - 1) ? 0 : phase_reg + 1;
		busTick   <= !rst && phase_reg == RATIO - 1;
	end
endmodule
`default_nettype wire

/* File: verification/tb_perf_event_counting.sv */
// tb_perf_event_counting: directed sequences for each event selection.
// assumes: inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_perf_event_counting import perf_event_pkg::*;;
	localparam int RATIO = 4;
	logic clk, rst, selectLoad, counterClear, coreHalted, otherCoreHalted, beingSnooped, rsDispatch, busTick;
	logic l2Refuse, l1RequestToL2, prefetchNew, storeRequest, snoopRequest, busOutstanding, snoopRespValid;
	logic snoopLineAbsent, snoopLineReadOnly, snoopOtherWrites, coreActive, l2PrefetchRequest, snoopGrant, storeGrant;
	logic [CODE_W-1:0] selectCode, selectMask, activeCode, activeMask;
	logic [CNT_W-1:0]  eventCount, dispatchCycles, stallCycles;
	snoop_resp_type    snoopRespKind;
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	bus_tick_source #(.RATIO(RATIO)) tick_u (.clk(clk), .rst(rst), .busTick(busTick));
	perf_event_counting dut_u (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic sel(input logic [CODE_W-1:0] c, m);
		selectLoad = 1'b1;
		selectCode = c;
		selectMask = m;
		cyc(1);
		selectLoad = 1'b0;
	endtask
	task automatic chk(input logic [CNT_W-1:0] e, g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: expected %h, got %h", $time, e, g);
		end
	endtask
	task automatic final_report;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// a hang shows as a run far past the under 200 cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		{selectLoad, counterClear, coreHalted, otherCoreHalted, beingSnooped, rsDispatch, l2Refuse, l1RequestToL2,
			prefetchNew, storeRequest, snoopRequest, busOutstanding, snoopRespValid, snoopLineAbsent,
			snoopLineReadOnly, snoopOtherWrites} = '0;
		{selectCode, selectMask} = '0;
		snoopRespKind = RESP_NONE;
		rst = 1'b1;
		cyc(3);
		rst = 1'b0;
		cyc(1);
		// mask is ignored for this code
		sel(EV_L2_REFUSAL, 8'h5A);
		l2Refuse = 1'b1;
		cyc(5);
		l2Refuse = 1'b0;
		cyc(2);
		chk(40'h5, eventCount);
		l1RequestToL2 = 1'b1;
		sel(EV_L2_IDLE, UM_NONE);
		cyc(3);
		l1RequestToL2 = 1'b0;
		cyc(2);
		l1RequestToL2 = 1'b1;
		cyc(1);
		chk(40'h2, eventCount);
		sel(EV_UNHALTED, UM_CORE_CYCLES);
		cyc(4);
		coreHalted = 1'b1;
		beingSnooped = 1'b1;
		cyc(3);
		chk(40'h4, eventCount);
		chk(40'h1, CNT_W'(coreActive));
		beingSnooped = 1'b0;
		cyc(2);
		chk(40'h0, CNT_W'(coreActive));
		coreHalted = 1'b0;
		sel(EV_UNHALTED, UM_REF_CYCLES);
		cyc(4 * RATIO);
		chk(40'h4, eventCount);
		sel(EV_UNHALTED, UM_SERIAL);
		cyc(4 * RATIO);
		otherCoreHalted = 1'b1;
		cyc(4 * RATIO);
		chk(40'h4, eventCount);
		sel(EV_BUS_IDLE, UM_NONE);
		busOutstanding = 1'b1;
		cyc(4 * RATIO);
		busOutstanding = 1'b0;
		cyc(4 * RATIO);
		chk(40'h4, eventCount);
		sel(EV_L1_PREFETCH, UM_NONE);
		prefetchNew = 1'b1;
		cyc(1);
		prefetchNew = 1'b0;
		l2Refuse = 1'b1;
		cyc(2);
		chk(40'h1, CNT_W'(l2PrefetchRequest));
		l2Refuse = 1'b0;
		cyc(1);
		chk(40'h0, CNT_W'(l2PrefetchRequest));
		chk(40'h3, eventCount);
		sel(EV_L1_PREFETCH, 8'h01);
		prefetchNew = 1'b1;
		cyc(1);
		prefetchNew = 1'b0;
		cyc(2);
		chk(40'h0, eventCount);
		sel(EV_SHARE_SNOOP, UM_SHARE);
		storeRequest = 1'b1;
		snoopRequest = 1'b1;
		// causes 3..7 qualify, 1 and 2 do not
		for (int i = 1; i < 8; i++) begin
			{snoopLineAbsent, snoopLineReadOnly, snoopOtherWrites} = i[2:0];
			cyc(1);
		end
		chk(40'h0, CNT_W'(storeGrant));
		snoopRequest = 1'b0;
		cyc(1);
		chk(40'h1, CNT_W'(storeGrant));
		chk(40'h5, eventCount);
		storeRequest = 1'b0;
		sel(EV_SNOOP_RESP, UM_NONE);
		snoopRespValid = 1'b1;
		for (int i = 0; i < 4; i++) begin
			snoopRespKind = snoop_resp_type'(i);
			cyc(1);
		end
		snoopRespValid = 1'b0;
		cyc(1);
		chk(40'h3, eventCount);
		// unit mask outside 00..02 under code 3C, and an unknown code
		sel(EV_UNHALTED, 8'h03);
		cyc(4);
		chk(40'h0, eventCount);
		chk(40'h3C, CNT_W'(activeCode));
		chk(40'h03, CNT_W'(activeMask));
		sel(8'h55, UM_NONE);
		cyc(4);
		chk(40'h0, eventCount);
		chk(40'h00, CNT_W'(activeMask));
		counterClear = 1'b1;
		cyc(1);
		counterClear = 1'b0;
		for (int i = 0; i < 6; i++) begin
			rsDispatch = i < 2;
			cyc(1);
		end
		coreHalted = 1'b1;
		cyc(2);
		chk(40'h2, dispatchCycles);
		chk(40'h4, stallCycles);
		final_report();
	end
endmodule
`default_nettype wire
